//--- fbsp_dll_end.sv
/*
 * Link layer end: software register port, one-symbol transmit slot,
 * receive capture, over-length controls and a level interrupt.
 * Assumes the physical end on the interface and a single clock.
 */
`timescale 1ns/1ps
module fbsp_dll_end
   import fbsp_pkg::*;
(
   input  wire logic                      clock_in,
   input  wire logic                      srst_in,
   fbsp_link_if.dll                       link,
   input  wire logic [fbsp_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [31:0]               wdata_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [31:0]               rdata_out,
   output logic                           irq_out
);
   import fbsp_pkg::*;

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   logic            slot_full;
   fbsp_sym_t       slot_sym;
   logic            slot_frame;
   fbsp_sym_t       rx_last;
   logic [EV_W-1:0] event_reg;
   logic [EV_W-1:0] mask_reg;
   logic [EV_W-1:0] new_ev;
   logic [EV_W-1:0] next_event;
   logic            lock_q;
   logic            jab_q;

   // Clear is a single-cycle pulse, low in all other cycles.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         link.overlength_type_sel  <= CTRL_TYPE_RST;
         link.overlength_clear_req <= 1'b0;
         mask_reg                  <= MASK_RST;
      end else begin
         link.overlength_clear_req <= wr_in && addr_in == REG_CTRL && wdata_in[CTRL_CLEAR];
         if (wr_in && addr_in == REG_CTRL) begin
            link.overlength_type_sel <= wdata_in[CTRL_TYPE];
         end
         if (wr_in && addr_in == REG_MASK) begin
            mask_reg <= wdata_in[EV_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Transmit slot
   // ----------------------------------------------------------------------
   // A write while the slot is full is dropped; software polls the busy bit.
   // Without a queued symbol the link idles at zero with the qualifier low.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         slot_full      <= 1'b0;
         slot_sym       <= SYM_ZERO;
         slot_frame     <= 1'b0;
         link.tx_symbol <= SYM_ZERO;
         link.tx_frame  <= 1'b0;
      end else begin
         if (link.sym_tick) begin
            link.tx_symbol <= (slot_full && slot_frame) ? slot_sym : SYM_ZERO;
            link.tx_frame  <= slot_full && slot_frame;
            slot_full      <= 1'b0;
         end else if (wr_in && addr_in == REG_TXSYM && !slot_full) begin
            slot_full  <= 1'b1;
            slot_sym   <= fbsp_sym_t'(wdata_in[1:0]);
            slot_frame <= wdata_in[TX_FRAME];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------------
   always_comb begin
      new_ev              = '0;
      new_ev[EV_RXSYM]    = link.rx_sym_stb;
      new_ev[EV_FSTART]   = link.frame_valid && !link.status_stb && link.rx_sym_stb;
      new_ev[EV_STATUS]   = link.status_stb;
      new_ev[EV_JABBER]   = link.overlength_ind && !jab_q;
      new_ev[EV_TXTAKEN]  = link.sym_tick && slot_full;
      new_ev[EV_LOCKLOST] = lock_q && !link.rx_lock_ind;
      // A read clears the bits it returned; a new event in that cycle stays.
      next_event = (rd_in && addr_in == REG_EVENT) ? new_ev : (event_reg | new_ev);
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         event_reg <= '0;
         irq_out   <= 1'b0;
         lock_q    <= 1'b0;
         jab_q     <= 1'b0;
         rx_last   <= SYM_ZERO;
      end else begin
         event_reg <= next_event;
         irq_out   <= |(next_event & mask_reg);
         lock_q    <= link.rx_lock_ind;
         jab_q     <= link.overlength_ind;
         if (link.rx_sym_stb) begin
            rx_last <= link.rx_symbol;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read port: data stand in the cycle after the strobe, zero otherwise.
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in || !rd_in) begin
         rdata_out <= '0;
      end else begin
         case (addr_in)
            REG_CTRL:  rdata_out <= {31'h0, link.overlength_type_sel};
            REG_STAT:  rdata_out <= {24'h0, slot_full, link.rx_frame_status,
                                     link.overlength_ind, link.carrier_present_ind,
                                     link.frame_valid, link.rx_lock_ind, 1'b0};
            REG_EVENT: rdata_out <= {26'h0, event_reg};
            REG_MASK:  rdata_out <= {26'h0, mask_reg};
            REG_TXSYM: rdata_out <= {29'h0, slot_frame, slot_sym};
            REG_RXSYM: rdata_out <= {30'h0, rx_last};
            default:   rdata_out <= '0;
         endcase
      end
   end
endmodule : fbsp_dll_end

//--- fbsp_link_if.sv
/*
 * Symbol-level connection between the physical end and the link layer end.
 * Assumes both ends run on the same clock; no clocking block is used.
 */
`timescale 1ns/1ps
interface fbsp_link_if;
   import fbsp_pkg::*;

   logic         sym_tick;
   fbsp_sym_t    rx_symbol;
   logic         rx_sym_stb;
   logic         rx_lock_ind;
   logic         frame_valid;
   logic         carrier_present_ind;
   fbsp_status_t rx_frame_status;
   logic         status_stb;
   logic         overlength_ind;
   fbsp_sym_t    tx_symbol;
   logic         tx_frame;
   logic         overlength_type_sel;
   logic         overlength_clear_req;

   modport dev (output sym_tick, rx_symbol, rx_sym_stb, rx_lock_ind, frame_valid,
                carrier_present_ind, rx_frame_status, status_stb, overlength_ind,
                input tx_symbol, tx_frame, overlength_type_sel, overlength_clear_req);
   modport dll (input sym_tick, rx_symbol, rx_sym_stb, rx_lock_ind, frame_valid,
                carrier_present_ind, rx_frame_status, status_stb, overlength_ind,
                output tx_symbol, tx_frame, overlength_type_sel, overlength_clear_req);
endinterface : fbsp_link_if

//--- fbsp_link_properties.sv
/* Assertions on the symbol link between the physical and link ends.
   Assumes one clock and the link signals wired in by name. */
`timescale 1ns/1ps
module fbsp_link_properties
   import fbsp_pkg::*;
(
   input wire logic                   clock_in,
   input wire logic                   srst_in,
   input wire logic                   sym_tick,
   input wire logic                   rx_sym_stb,
   input wire logic                   rx_lock_ind,
   input wire logic                   frame_valid,
   input wire fbsp_pkg::fbsp_status_t rx_frame_status,
   input wire logic                   status_stb,
   input wire logic                   overlength_ind,
   input wire logic                   overlength_clear_req,
   input wire fbsp_pkg::fbsp_sym_t    tx_symbol,
   input wire logic                   tx_frame
);
   // All checks share one clock and rest during reset.
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   property p_lock_fv; frame_valid |-> rx_lock_ind; endproperty
   a_lock_fv: assert property (p_lock_fv) else $error("frame without lock");
   property p_fv_drop; !rx_lock_ind |=> !frame_valid; endproperty
   a_fv_drop: assert property (p_fv_drop) else $error("frame kept after lock loss");
   property p_fv_rise; $rose(frame_valid) |-> $past(rx_lock_ind, 2); endproperty
   a_fv_rise: assert property (p_fv_rise) else $error("lock late for delimiter");
   property p_present; rx_sym_stb |-> $past(rx_lock_ind); endproperty
   a_present: assert property (p_present) else $error("symbol shown unlocked");
   property p_ovl_hold; overlength_ind && !overlength_clear_req |=> overlength_ind; endproperty
   a_ovl_hold: assert property (p_ovl_hold) else $error("over-length not held");
   property p_ovl_set; $rose(overlength_ind) |-> $past(frame_valid); endproperty
   a_ovl_set: assert property (p_ovl_set) else $error("over-length outside frame");
   property p_idle_zero; !tx_frame |-> tx_symbol == SYM_ZERO; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("idle symbol not zero");
   property p_tx_tick; $changed(tx_frame) |-> $past(sym_tick); endproperty
   a_tx_tick: assert property (p_tx_tick) else $error("frame flag off tick");
   c_frame: cover property ($rose(frame_valid));
   c_abort: cover property (status_stb && rx_frame_status == ST_ABORT);
   c_ovl: cover property ($rose(overlength_ind));
endmodule : fbsp_link_properties

//--- fbsp_phy_end.sv
/*
 * Physical end of the symbol interface: lock, frame, carrier, status and
 * over-length detection on receive, symbol pass-through on transmit.
 * Assumes the attachment unit delivers one decoded symbol per strobe, all
 * pins synchronous to clock_in, and the link end on the interface.
 */
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - Symbols are zero, one, non-data plus, non-data minus.
// - Lock rises on correctly timed arriving symbols.
// - Lock falls on silence or timing violation.
// - Lock is high before delimiter symbols appear.
// - Frame rises on locked start delimiter.
// - Frame falls on next non-data or lock loss.
// - Carrier high if seen in last four symbols.
// - Decoded symbols presented only while locked.
// - Status Normal: one delimiter, clean data, end.
// - Status Abort: second start delimiter seen.
// - Status Invalid: stray non-data after start.
// - Link sends zero when idle.
// - Link frame qualifier marks real symbols only.
// - Node type: over-length at 8192 symbols.
// - Repeater type: over-length at 16384 symbols.
// - Over-length latched until clear or reset.
// - Link raises clear only to release latch.
// - Link selects node or repeater type.
module fbsp_phy_end
   import fbsp_pkg::*;
#(
   parameter int SYM_CYC_P = fbsp_pkg::SYM_CYC,
   parameter int TOL_CYC_P = fbsp_pkg::TOL_CYC,
   parameter int JAB_NODE  = fbsp_pkg::JAB_NODE_SYMS,
   parameter int JAB_RPT   = fbsp_pkg::JAB_RPT_SYMS
) (
   input  wire logic                clock_in,
   input  wire logic                srst_in,
   fbsp_link_if.dev                 link,
   input  wire logic                mau_rx_stb_in,
   input  wire fbsp_pkg::fbsp_sym_t mau_rx_symbol_in,
   input  wire logic                mau_rx_carrier_in,
   output fbsp_pkg::fbsp_sym_t      mau_tx_symbol_out,
   output logic                     mau_tx_enable_out
);
   import fbsp_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   localparam int GAP_MAX = SYM_CYC_P + TOL_CYC_P + 1;
   localparam int GAP_W   = $clog2(GAP_MAX + 1);

   generate
      if (TOL_CYC_P >= SYM_CYC_P || SYM_CYC_P < 4) begin : g_bad_time
         $error("Symbol timing parameters cannot be served");
      end
      if (JAB_NODE < 1 || JAB_RPT < 1 || (JAB_NODE | JAB_RPT) >= (1 << JAB_CNT_W)) begin : g_bad_jab
         $error("Over-length thresholds out of counter range");
      end
   endgenerate

   typedef enum {RX_HUNT, RX_FRAME, RX_DELIM} fbsp_rx_state_t;

   // Non-data symbols carry the top code bit set.
   function automatic logic is_nondata(input fbsp_sym_t s);
      return s[1];
   endfunction : is_nondata

   // Threshold chosen by the node / repeater selection.
   function automatic logic [JAB_CNT_W-1:0] jab_limit(input logic node);
      return node ? JAB_CNT_W'(JAB_NODE) : JAB_CNT_W'(JAB_RPT);
   endfunction : jab_limit

   // ----------------------------------------------------------------------
   // Symbol time base and carrier window
   // ----------------------------------------------------------------------
   logic                       sym_tick;
   logic                       carrier_seen;
   logic [CARRIER_WIN-2:0]     carrier_hist;

   fbsp_sym_timer #(
      .DIV (SYM_CYC_P)
   ) u_timer (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .tick_out (sym_tick)
   );

   // Carrier is folded over each symbol time, then kept for four of them.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         carrier_seen              <= 1'b0;
         carrier_hist              <= '0;
         link.carrier_present_ind  <= 1'b0;
      end else if (sym_tick) begin
         carrier_seen <= 1'b0;
         carrier_hist <= {carrier_hist[CARRIER_WIN-3:0], carrier_seen | mau_rx_carrier_in};
         link.carrier_present_ind <= (|carrier_hist) | carrier_seen | mau_rx_carrier_in;
      end else begin
         carrier_seen <= carrier_seen | mau_rx_carrier_in;
      end
   end

   // ----------------------------------------------------------------------
   // Lock: interval check between attachment unit strobes
   // ----------------------------------------------------------------------
   logic [GAP_W-1:0] gap_cnt;
   logic [1:0]       good_cnt;
   logic [1:0]       next_good_cnt;
   logic             next_lock;
   logic             interval_ok;
   logic             timed_out;
   logic             present;

   assign interval_ok = (gap_cnt >= GAP_W'(SYM_CYC_P - TOL_CYC_P))
                     && (gap_cnt <= GAP_W'(SYM_CYC_P + TOL_CYC_P));
   assign timed_out   = (gap_cnt == GAP_W'(GAP_MAX));
   // Only a symbol that arrives with lock already up is passed on, so the
   // first delimiter symbol can never precede the lock indication.
   assign present     = mau_rx_stb_in && interval_ok && link.rx_lock_ind;

   // Zero means no earlier strobe, which never passes the interval check.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         gap_cnt <= '0;
      end else if (mau_rx_stb_in) begin
         gap_cnt <= GAP_W'(1);
      end else if (gap_cnt != '0 && !timed_out) begin
         gap_cnt <= gap_cnt + 1'b1;
      end
   end

   // Lock needs LOCK_GOOD well timed strobes in a row.
   always_comb begin
      next_good_cnt = good_cnt;
      next_lock     = link.rx_lock_ind;
      if (mau_rx_stb_in && interval_ok) begin
         if (good_cnt != 2'(LOCK_GOOD)) begin
            next_good_cnt = good_cnt + 1'b1;
         end
         next_lock = (next_good_cnt == 2'(LOCK_GOOD));
      end else if (mau_rx_stb_in || timed_out) begin
         next_good_cnt = '0;
         next_lock     = 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         good_cnt         <= '0;
         link.rx_lock_ind <= 1'b0;
      end else begin
         good_cnt         <= next_good_cnt;
         link.rx_lock_ind <= next_lock;
      end
   end

   // Presented symbol stream.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         link.rx_symbol  <= SYM_ZERO;
         link.rx_sym_stb <= 1'b0;
      end else begin
         link.rx_sym_stb <= present;
         if (present) begin
            link.rx_symbol <= mau_rx_symbol_in;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Delimiter detection and frame status
   // ----------------------------------------------------------------------
   logic [15:0]      window;
   logic [15:0]      next_window;
   logic             sd_hit;
   logic             ed_hit;
   logic [3:0]       delim_cnt;
   logic             frame_start;
   fbsp_rx_state_t   rx_state;

   assign next_window = {window[13:0], mau_rx_symbol_in};
   assign sd_hit      = present && (next_window == SD_PATTERN);
   assign ed_hit      = present && (next_window == ED_PATTERN);

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         window <= '0;
      end else if (present) begin
         window <= next_window;
      end
   end

   // A stray non-data symbol that forms no delimiter within DELIM_LEN
   // symbols is judged Invalid; a second start delimiter aborts the frame
   // and opens the next one at once.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rx_state             <= RX_HUNT;
         link.frame_valid     <= 1'b0;
         link.rx_frame_status <= ST_NONE;
         link.status_stb      <= 1'b0;
         delim_cnt            <= '0;
         frame_start          <= 1'b0;
      end else begin
         link.status_stb <= 1'b0;
         frame_start     <= 1'b0;
         case (rx_state)
            RX_HUNT: begin
               if (sd_hit) begin
                  rx_state             <= RX_FRAME;
                  link.frame_valid     <= 1'b1;
                  link.rx_frame_status <= ST_NONE;
                  frame_start          <= 1'b1;
               end
            end
            RX_FRAME: begin
               if (!next_lock) begin
                  rx_state             <= RX_HUNT;
                  link.frame_valid     <= 1'b0;
                  link.rx_frame_status <= ST_INVALID;
                  link.status_stb      <= 1'b1;
               end else if (present && is_nondata(fbsp_sym_t'(mau_rx_symbol_in))) begin
                  rx_state         <= RX_DELIM;
                  link.frame_valid <= 1'b0;
                  delim_cnt        <= 4'h1;
               end
            end
            RX_DELIM: begin
               if (!next_lock) begin
                  rx_state             <= RX_HUNT;
                  link.rx_frame_status <= ST_INVALID;
                  link.status_stb      <= 1'b1;
               end else if (sd_hit) begin
                  rx_state             <= RX_FRAME;
                  link.frame_valid     <= 1'b1;
                  link.rx_frame_status <= ST_ABORT;
                  link.status_stb      <= 1'b1;
                  frame_start          <= 1'b1;
               end else if (ed_hit) begin
                  rx_state             <= RX_HUNT;
                  link.rx_frame_status <= ST_NORMAL;
                  link.status_stb      <= 1'b1;
               end else if (present) begin
                  if (delim_cnt == 4'(DELIM_LEN - 1)) begin
                     rx_state             <= RX_HUNT;
                     link.rx_frame_status <= ST_INVALID;
                     link.status_stb      <= 1'b1;
                  end else begin
                     delim_cnt <= delim_cnt + 1'b1;
                  end
               end
            end
            default: begin
               rx_state         <= RX_HUNT;
               link.frame_valid <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Over-length detection
   // ----------------------------------------------------------------------
   logic [JAB_CNT_W-1:0] sym_cnt;

   // The count saturates so a very long frame cannot wrap below the limit.
   always_ff @(posedge clock_in) begin
      if (srst_in || frame_start) begin
         sym_cnt <= '0;
      end else if (link.frame_valid && present && !(&sym_cnt)) begin
         sym_cnt <= sym_cnt + 1'b1;
      end
   end

   // Set wins over a clear arriving in the same cycle; reset is node init.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         link.overlength_ind <= 1'b0;
      end else if (link.frame_valid && present
                   && sym_cnt >= jab_limit(link.overlength_type_sel) - 1'b1) begin
         link.overlength_ind <= 1'b1;
      end else if (link.overlength_clear_req) begin
         link.overlength_ind <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------------
   // The link end changes its symbol right after each tick it sees, so the
   // value sampled here at the next tick is always settled.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         link.sym_tick     <= 1'b0;
         mau_tx_symbol_out <= SYM_ZERO;
         mau_tx_enable_out <= 1'b0;
      end else begin
         link.sym_tick <= sym_tick;
         if (sym_tick) begin
            mau_tx_symbol_out <= link.tx_frame ? link.tx_symbol : SYM_ZERO;
            mau_tx_enable_out <= link.tx_frame;
         end
      end
   end
endmodule : fbsp_phy_end

//--- fbsp_pkg.sv
/*
 * Shared types and constants of the fieldbus symbol interface: symbol and
 * frame status codes, timing counts, delimiter patterns and the register map
 * of the link layer end.
 * Assumes a 200 MHz system clock; every other rate is derived from it.
 */
package fbsp_pkg;

   // ----------------------------------------------------------------------
   // Symbol and status codes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SYM_ZERO        = 2'h0,
      SYM_ONE         = 2'h1,
      sym_nondata_pos = 2'h2,
      sym_nondata_neg = 2'h3
   } fbsp_sym_t;

   typedef enum logic [1:0] {
      ST_NONE    = 2'h0,
      ST_NORMAL  = 2'h1,
      ST_ABORT   = 2'h2,
      ST_INVALID = 2'h3
   } fbsp_status_t;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SYM_TIME_NS   = 1000;
   localparam int SYM_CYC       = (SYM_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int TOL_CYC       = 2;
   localparam int LOCK_GOOD     = 2;
   localparam int CARRIER_WIN   = 4;
   localparam int DELIM_LEN     = 8;
   localparam int JAB_NODE_SYMS = 8192;
   localparam int JAB_RPT_SYMS  = 16384;
   localparam int JAB_CNT_W     = 15;

   // Delimiters, oldest symbol in the top bits, two bits per symbol.
   localparam logic [15:0] SD_PATTERN = 16'h6d38;
   localparam logic [15:0] ED_PATTERN = 16'h6ee1;

   // ----------------------------------------------------------------------
   // Register map of the link layer end (byte addresses)
   // ----------------------------------------------------------------------
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_STAT   = 8'h04;
   localparam logic [7:0]  REG_EVENT  = 8'h08;
   localparam logic [7:0]  REG_MASK   = 8'h0c;
   localparam logic [7:0]  REG_TXSYM  = 8'h10;
   localparam logic [7:0]  REG_RXSYM  = 8'h14;
   localparam int          CTRL_TYPE  = 0;
   localparam int          CTRL_CLEAR = 1;
   localparam logic        CTRL_TYPE_RST = 1'b1;
   localparam int          TX_FRAME   = 2;
   localparam int          EV_W       = 6;
   localparam int          EV_RXSYM   = 0;
   localparam int          EV_FSTART  = 1;
   localparam int          EV_STATUS  = 2;
   localparam int          EV_JABBER  = 3;
   localparam int          EV_TXTAKEN = 4;
   localparam int          EV_LOCKLOST = 5;
   localparam logic [5:0]  MASK_RST   = 6'h00;

endpackage : fbsp_pkg

//--- fbsp_sym_timer.sv
/*
 * Symbol time divider: one-cycle enable pulse every DIV clock cycles.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module fbsp_sym_timer #(
   parameter int DIV = 200
) (
   input  wire logic clock_in,
   input  wire logic srst_in,
   output logic      tick_out
);
   localparam int W = $clog2(DIV);

   logic [W-1:0] cnt;

   generate
      if (DIV < 4) begin : g_bad_div
         $error("DIV too small");
      end
   endgenerate

   // Free-running count; the pulse comes from a flop, one cycle wide.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cnt      <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= (cnt == W'(DIV - 1));
         cnt      <= (cnt == W'(DIV - 1)) ? '0 : cnt + 1'b1;
      end
   end
endmodule : fbsp_sym_timer

//--- fieldbus_symbol_phy_interface_tb.sv
/* Bench for both ends of the symbol link.
   Assumes short counts: 16-cycle symbols, over-length at 20 and 40. */
`timescale 1ns/1ps
`define CK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module fieldbus_symbol_phy_interface_tb;
   import fbsp_pkg::*;
   typedef struct {int n; int kind; fbsp_status_t st;} fbsp_row_t;
   // Rows: data length, closing kind (end, second start, stray), status.
   fbsp_row_t   rows[3] = '{'{3, 0, ST_NORMAL}, '{2, 1, ST_ABORT}, '{3, 2, ST_INVALID}};
   logic        clock_in, srst_in, stb, car, wr, rd, irq, tx_en;
   fbsp_sym_t   sym, tx_sym;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, d;
   int          fails, n_checks, k;
   fbsp_link_if lnk ();
   fbsp_phy_end #(.SYM_CYC_P(16), .JAB_NODE(20), .JAB_RPT(40)) u_fbsp_phy_end (.clock_in,
      .srst_in, .link(lnk.dev), .mau_rx_stb_in(stb), .mau_rx_symbol_in(sym),
      .mau_rx_carrier_in(car), .mau_tx_symbol_out(tx_sym), .mau_tx_enable_out(tx_en));
   fbsp_dll_end u_fbsp_dll_end (.clock_in, .srst_in, .link(lnk.dll), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq));
   fbsp_link_properties u_fbsp_link_properties (.clock_in, .srst_in,
      .sym_tick(lnk.sym_tick), .rx_sym_stb(lnk.rx_sym_stb), .rx_lock_ind(lnk.rx_lock_ind),
      .frame_valid(lnk.frame_valid), .rx_frame_status(lnk.rx_frame_status),
      .status_stb(lnk.status_stb), .overlength_ind(lnk.overlength_ind),
      .overlength_clear_req(lnk.overlength_clear_req), .tx_symbol(lnk.tx_symbol),
      .tx_frame(lnk.tx_frame));
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   // One symbol every 15 cycles, so one register access between keeps the gap legal.
   task automatic sym_tx(fbsp_sym_t s);
      @(posedge clock_in);
      stb <= 1'b1;
      sym <= s;
      @(posedge clock_in);
      stb <= 1'b0;
      repeat (13) @(posedge clock_in);
   endtask : sym_tx
   task automatic delim(logic [15:0] p);
      for (int i = 7; i >= 0; i--) sym_tx(fbsp_sym_t'(p[2*i+:2]));
   endtask : delim
   task automatic wreg(logic [7:0] a, logic [31:0] v);
      @(posedge clock_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(logic [7:0] a);
      @(posedge clock_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task automatic frame(int n, int kind);
      repeat (4) sym_tx(SYM_ONE);
      delim(SD_PATTERN);
      rreg(REG_STAT);
      `CK(d[2:1], 2'h3)
      repeat (n) sym_tx(SYM_ZERO);
      if (kind == 2) begin
         sym_tx(sym_nondata_pos);
         rreg(REG_STAT);
         `CK(d[2], 1'b0)
         repeat (8) sym_tx(SYM_ONE);
      end else
         delim(kind == 1 ? SD_PATTERN : ED_PATTERN);
   endtask : frame
   task automatic close_out;
      if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   initial begin
      {srst_in, stb, car, wr, rd, addr, wdata} = '0;
      sym = SYM_ZERO;
      srst_in = 1'b1;
      repeat (5) @(posedge clock_in);
      srst_in <= 1'b0;
      rreg(REG_CTRL);
      `CK(d, 32'h1)
      foreach (rows[i]) begin
         frame(rows[i].n, rows[i].kind);
         rreg(REG_STAT);
         `CK(d[6:5], rows[i].st)
         repeat (40) @(posedge clock_in);
      end
      rreg(REG_STAT);
      `CK(d[3:1], 3'h0)
      car <= 1'b1;
      repeat (20) @(posedge clock_in);
      car <= 1'b0;
      rreg(REG_STAT);
      `CK(d[3], 1'b1)
      repeat (100) @(posedge clock_in);
      rreg(REG_STAT);
      `CK(d[3], 1'b0)
      wreg(REG_MASK, 32'h8);
      frame(24, 0);
      rreg(REG_STAT);
      `CK({irq, d[4]}, 2'h3)
      rreg(REG_EVENT);
      `CK(d[3], 1'b1)
      rreg(REG_STAT);
      `CK({irq, d[4]}, 2'h1)
      wreg(REG_CTRL, 32'h0);
      repeat (3) @(posedge clock_in);
      rreg(REG_STAT);
      `CK(d[4], 1'b1)
      wreg(REG_CTRL, 32'h2);
      repeat (3) @(posedge clock_in);
      rreg(REG_STAT);
      `CK(d[4], 1'b0)
      frame(24, 0);
      rreg(REG_STAT);
      `CK(d[4], 1'b0)
      frame(44, 0);
      rreg(REG_STAT);
      `CK(d[4], 1'b1)
      // A slot write in the tick cycle is dropped, so write just after a tick.
      #1;
      for (k = 0; k < 20 && lnk.sym_tick !== 1'b1; k++) #5;
      `CK(k < 20, 1'b1)
      wreg(REG_TXSYM, 32'h5);
      #1;
      for (int i = 0; i < 100 && tx_en !== 1'b1; i++) #5;
      `CK({tx_en, tx_sym}, {1'b1, SYM_ONE})
      close_out();
   end
endmodule : fieldbus_symbol_phy_interface_tb
